// >>> rtl/dbsm_top.sv
// Status and mode register of a dual-bus transceiver, host side logic.
// Synchronises async host pins (strobe, selects, data, sync, bus select);
// assumes decoder status already on ref_clk; master clear is the rst input.
// Function
// - Bits 0,1 disable bus A/B transmitters
// - Bits 2,3 enable receivers, default one
// - Frame sync is bit 4 OR sync pin
// - Transmit bus is bit 5 OR select pin
// - Data read picks A or B likewise
// - Bit 6 always reads zero
// - Bit 7 mirrors word ready A
// - Ready clears on read or new word
// - Contiguous words clear ready quickly
// - Received word holds until next ready
// - Bit 8 holds last sync kind A
// - Data read A drives sync kind out
// - Bit 9 high while bus A idle
// - Bit 10 flags bad encoding on A
// - Bits 11-14 same for bus B
// - Map select high picks this register
// - Master clear restores all defaults
// - Bit 15 open 3.5 to 18.5 us
`timescale 1ns/1ns
`default_nettype none
module dbsm_top
	import dbsm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic host_strobe_n, // Active-low host strobe pin
	input wire logic read_not_write, // High for read cycles
	input wire logic map_select_pin, // High selects status_mode_word
	input wire logic bus_select_pin,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	input wire logic frame_type_in,
	output logic frame_type_out,
	output logic frame_type_oe,
	input wire dbsm_rx_t rx_a,
	input wire dbsm_rx_t rx_b,
	input wire logic tx_start, // Pulse: encoder begins a word
	output logic tx_load, // Pulse: new transmit word written
	output logic [15:0] tx_word,
	output logic tx_cmd_sync,
	output logic tx_bus_b,
	output logic tx_off_a,
	output logic tx_off_b,
	output logic word_ready_a,
	output logic word_ready_b
);
	// Pin synchronisers: stage one only feeds stage two
	logic [20:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_s1_q <= 21'h00_0000;
			pin_s2_q <= 21'h00_0000;
		end else begin
			pin_s1_q <= {~host_strobe_n, read_not_write, map_select_pin,
				bus_select_pin, frame_type_in, data_in};
			pin_s2_q <= pin_s1_q;
		end
	end
	logic stb, rd, reg_sel, bsel, fsync;
	logic [15:0] din;
	assign {stb, rd, reg_sel, bsel, fsync, din} = pin_s2_q;

	// Whole top-level state except the pin synchronisers
	typedef struct packed {
		dbsm_state_t st;
		logic [5:0] ctrl;
		logic [15:0] dout;
		logic oe;
		logic sync_oe;
		logic sync_out;
		logic load;
		logic [15:0] txw;
		logic cmd;
		logic busb;
		logic win;
		logic [WIN_CNT_W-1:0] win_cnt;
		logic win_run;
		logic rd_a;
		logic rd_b;
	} dbsm_top_t;
	dbsm_top_t s_q, s_d;

	logic [15:0] status_word;
	logic rdy_a, rdy_b, syn_a, syn_b, idl_a, idl_b, flt_a, flt_b;
	logic [15:0] rxw_a, rxw_b;
	logic bus_choice_b;

	// Bus choice combined with the pin
	assign bus_choice_b = s_q.ctrl[B_BUS_CHOICE] | bsel;

	// Assemble the readable register
	always_comb begin
		status_word = 16'h0000;
		status_word[5:0] = s_q.ctrl;
		status_word[B_UNUSED] = 1'b0;
		status_word[B_READY_A] = rdy_a;
		status_word[B_SYNC_A] = syn_a;
		status_word[B_IDLE_A] = idl_a;
		status_word[B_FAULT_A] = flt_a;
		status_word[B_READY_B] = rdy_b;
		status_word[B_SYNC_B] = syn_b;
		status_word[B_IDLE_B] = idl_b;
		status_word[B_FAULT_B] = flt_b;
		status_word[B_WINDOW] = s_q.win;
	end

	// Access sequencing, register writes, window timer
	always_comb begin
		s_d = s_q;
		s_d.load = 1'b0;
		s_d.rd_a = 1'b0;
		s_d.rd_b = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				if (stb) begin // One action per strobe
					s_d.st = ST_ACT;
					if (rd) begin
						s_d.oe = 1'b1;
						if (reg_sel) begin
							s_d.dout = status_word;
						end else if (bus_choice_b) begin
							s_d.dout = rxw_b;
							s_d.rd_b = 1'b1;
							s_d.sync_oe = 1'b1;
							s_d.sync_out = syn_b;
						end else begin
							s_d.dout = rxw_a;
							s_d.rd_a = 1'b1;
							s_d.sync_oe = 1'b1;
							s_d.sync_out = syn_a;
						end
					end else if (reg_sel) begin
						s_d.ctrl = din[5:0] & CTRL_MASK_W;
					end else begin
						s_d.load = 1'b1;
						s_d.txw = din;
						s_d.cmd = s_q.ctrl[B_TX_FRAME] | fsync;
						s_d.busb = bus_choice_b;
					end
				end
			end
			ST_ACT: begin
				if (!stb) begin
					s_d.st = ST_DONE;
					s_d.oe = 1'b0;
					s_d.sync_oe = 1'b0;
				end
			end
			ST_DONE: begin
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		// Window opens and closes relative to transmission start
		if (tx_start) begin
			s_d.win_run = 1'b1;
			s_d.win_cnt = '0;
			s_d.win = 1'b0;
		end else if (s_q.win_run) begin
			s_d.win_cnt = s_q.win_cnt + 1'b1;
			if (s_q.win_cnt == WIN_CNT_W'(WIN_OPEN_CYC - 1)) begin
				s_d.win = 1'b1;
			end
			if (s_q.win_cnt == WIN_CNT_W'(WIN_CLOSE_CYC - 1)) begin
				s_d.win = 1'b0;
				s_d.win_run = 1'b0;
			end
		end
	end

	// State register; master clear returns defaults
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RESET;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Per-bus receive status
	dbsm_bus_choice u_bus_choice_a (
		.ref_clk(ref_clk), .rst(rst), .rx(rx_a),
		.rx_en(s_q.ctrl[B_RX_EN_A]), .rd_pulse(s_q.rd_a),
		.ready(rdy_a), .sync_kind(syn_a), .idle(idl_a), .fault(flt_a), .word(rxw_a)
	);
	dbsm_bus_choice u_bus_choice_b (
		.ref_clk(ref_clk), .rst(rst), .rx(rx_b),
		.rx_en(s_q.ctrl[B_RX_EN_B]), .rd_pulse(s_q.rd_b),
		.ready(rdy_b), .sync_kind(syn_b), .idle(idl_b), .fault(flt_b), .word(rxw_b)
	);

	assign data_out = s_q.dout;
	assign data_oe = s_q.oe;
	assign frame_type_out = s_q.sync_out;
	assign frame_type_oe = s_q.sync_oe;
	assign tx_load = s_q.load;
	assign tx_word = s_q.txw;
	assign tx_cmd_sync = s_q.cmd;
	assign tx_bus_b = s_q.busb;
	assign tx_off_a = s_q.ctrl[B_TX_OFF_A];
	assign tx_off_b = s_q.ctrl[B_TX_OFF_B];
	assign word_ready_a = rdy_a;
	assign word_ready_b = rdy_b;

	a_one_load: assert property (@(posedge ref_clk) disable iff (rst)
		tx_load |=> !tx_load)
		else $error("transmit load longer than a cycle");
	a_cmd_or: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.st == ST_IDLE && stb && !rd && !reg_sel |=>
		tx_load && tx_cmd_sync == ($past(s_q.ctrl[B_TX_FRAME]) | $past(fsync)))
		else $error("sync kind not OR of bit and pin");
	a_bus_or: assert property (@(posedge ref_clk) disable iff (rst)
		tx_load |-> tx_bus_b == ($past(s_q.ctrl[B_BUS_CHOICE]) | $past(bsel)))
		else $error("bus not OR of bit and pin");
	a_bit6_zero: assert property (@(posedge ref_clk) disable iff (rst)
		data_oe && $rose(data_oe) && $past(reg_sel) |-> !data_out[B_UNUSED])
		else $error("unused bit read as one");
	a_sync_drive: assert property (@(posedge ref_clk) disable iff (rst)
		$past(s_q.st == ST_IDLE && stb && rd && !reg_sel && !bus_choice_b) |->
		frame_type_oe && frame_type_out == $past(syn_a))
		else $error("sync kind not driven on read A");
	a_win_open: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.win_run && s_q.win_cnt == WIN_CNT_W'(WIN_OPEN_CYC - 1) && !tx_start |=> s_q.win)
		else $error("window did not open");
	a_win_close: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.win_cnt == WIN_CNT_W'(WIN_CLOSE_CYC - 1) && s_q.win_run && !tx_start
		|=> !s_q.win)
		else $error("window did not close");
	a_ctrl_write: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.st == ST_IDLE && stb && !rd && reg_sel |=> s_q.ctrl == $past(din[5:0]))
		else $error("control bits not written");
endmodule
`default_nettype wire

// >>> pkg/dbsm_pkg.sv
// Package for the dual-bus status and mode register block.
// Assumes a 125 MHz ref_clk; all counts derive from it.
`default_nettype none
package dbsm_pkg;
	localparam int CLK_MHZ = 125;
	// Bit positions within status_mode_word
	localparam int B_TX_OFF_A = 0;
	localparam int B_TX_OFF_B = 1;
	localparam int B_RX_EN_A = 2;
	localparam int B_RX_EN_B = 3;
	localparam int B_TX_FRAME = 4;
	localparam int B_BUS_CHOICE = 5;
	localparam int B_UNUSED = 6;
	localparam int B_READY_A = 7;
	localparam int B_SYNC_A = 8;
	localparam int B_IDLE_A = 9;
	localparam int B_FAULT_A = 10;
	localparam int B_READY_B = 11;
	localparam int B_SYNC_B = 12;
	localparam int B_IDLE_B = 13;
	localparam int B_FAULT_B = 14;
	localparam int B_WINDOW = 15;
	// Writable control bits and their reset value
	localparam logic [5:0] CTRL_MASK_W = 6'h3f;
	localparam logic [5:0] CTRL_RESET = 6'h0c;
	// Next-word window timing, in nanoseconds and ref_clk cycles
	localparam int WIN_OPEN_NS = 3500;
	localparam int WIN_CLOSE_NS = 18500;
	localparam int WIN_OPEN_CYC = (WIN_OPEN_NS * CLK_MHZ + 999) / 1000;
	localparam int WIN_CLOSE_CYC = (WIN_CLOSE_NS * CLK_MHZ) / 1000;
	localparam int WIN_CNT_W = 12;

	// Receive side status of one bus, from its decoder
	typedef struct packed {
		logic word_valid; // One-cycle pulse: good word decoded
		logic word_sync; // Sync kind of that word
		logic [15:0] word; // Decoded word
		logic word_start; // Pulse: new word begins arriving
		logic activity; // Level: bus traffic seen
		logic code_err; // Pulse: bad Manchester encoding
	} dbsm_rx_t;

	// Host access strobe state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACT = 2'b01,
		ST_DONE = 2'b11
	} dbsm_state_t;
endpackage
`default_nettype wire

// >>> rtl/dbsm_bus_choice.sv
// One bus channel's receive status: word ready, sync, idle, fault and data.
// Assumes its decoder inputs are already on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module dbsm_bus_choice
	import dbsm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire dbsm_rx_t rx,
	input wire logic rx_en,
	input wire logic rd_pulse,
	output logic ready,
	output logic sync_kind,
	output logic idle,
	output logic fault,
	output logic [15:0] word
);
	// Whole channel state
	typedef struct packed {
		logic ready;
		logic sync_kind;
		logic idle;
		logic fault;
		logic [15:0] word;
	} dbsm_bus_choice_t;
	dbsm_bus_choice_t s_q, s_d;

	// Next-state logic; a disabled receiver ignores all bus activity
	always_comb begin
		s_d = s_q;
		if (rx_en) begin
			s_d.idle = ~rx.activity;
			if (rd_pulse || rx.word_start) begin
				s_d.ready = 1'b0;
			end
			if (rx.word_valid) begin
				s_d.ready = 1'b1; // set wins over clear
				s_d.word = rx.word; // overwrite only on new ready
				s_d.sync_kind = rx.word_sync;
				s_d.fault = 1'b0;
			end
			// Fault set wins over the clear by a good word
			if (rx.code_err) begin
				s_d.fault = 1'b1;
			end
		end else begin
			s_d.idle = 1'b1;
		end
	end

	// State register, cleared by master clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ready = s_q.ready;
	assign sync_kind = s_q.sync_kind;
	assign idle = s_q.idle;
	assign fault = s_q.fault;
	assign word = s_q.word;

	a_ready_set: assert property (@(posedge ref_clk) disable iff (rst)
		rx_en && rx.word_valid |=> ready && word == $past(rx.word))
		else $error("ready not set on valid word");
	a_ready_clr: assert property (@(posedge ref_clk) disable iff (rst)
		rx_en && rd_pulse && !rx.word_valid |=> !ready)
		else $error("ready not cleared by read");
	a_word_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!$rose(ready) && !rx.word_valid |=> $stable(word))
		else $error("word changed without new ready");
	a_rx_off: assert property (@(posedge ref_clk) disable iff (rst)
		!rx_en |=> $stable(word) && $stable(fault))
		else $error("disabled receiver changed state");
endmodule
`default_nettype wire

// >>> sim/dbsm_host.sv
// Host processor model: strobed reads and writes on the parallel bus.
// Assumes ref_clk at 125 MHz and a device that synchronises the strobe.
`timescale 1ns/1ns
`default_nettype none
module dbsm_host (
	input wire logic ref_clk,
	input wire logic [15:0] rd_data,
	input wire logic sync_in,
	output logic strobe_n,
	output logic rnw,
	output logic map_sel,
	output logic [15:0] wr_data,
	output logic sync_out
);
	// Idle bus: strobe high, released lines at pull-down level
	initial begin
		strobe_n = 1'b1;
		rnw = 1'b1;
		map_sel = 1'b0;
		wr_data = 16'h0000;
		sync_out = 1'b0;
	end
	// One strobed cycle; pins settle three cycles before the strobe
	task automatic xfer(input logic rd, input logic map, input logic [15:0] wd,
		input logic sy, output logic [15:0] rdv, output logic rsy);
		@(posedge ref_clk);
		rnw <= rd;
		map_sel <= map;
		wr_data <= rd ? 16'h0000 : wd;
		sync_out <= rd ? 1'b0 : sy;
		repeat (3) @(posedge ref_clk);
		strobe_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		rdv = rd_data;
		rsy = sync_in;
		@(posedge ref_clk);
		strobe_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wr_data <= 16'h0000;
		sync_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the status and mode register block.
// Assumes the host model drives the strobed bus; bench drives decoders.
`timescale 1ns/1ns
`default_nettype none
module testbench
	import dbsm_pkg::*;
;
	logic ref_clk, rst, bus_sel, tx_start, strobe_n, rnw, map_sel, h_sync;
	logic data_oe, ft_out, ft_oe, rsy, tx_load, tx_cmd, tx_bus_b;
	logic tx_off_a, tx_off_b, rdy_a, rdy_b;
	logic [15:0] h_wd, data_out, rdv, tx_word, seen_word;
	logic [1:0] seen_flags;
	logic [3:0] k;
	dbsm_rx_t rx_a, rx_b;
	int error_cnt, cmp_count;
	int loads = 0;
	// Rows: value written, value read back
	logic [15:0] rows [4][2] = '{'{16'h0000, 16'h2200}, '{16'h003f, 16'h223f},
		'{16'hffc5, 16'h2205}, '{16'h0015, 16'h2215}};
	// Released pins sit at their pull-down level
	wire logic [15:0] rd_bus = data_oe ? data_out : 16'h0000;
	wire logic ft_in = ft_oe ? ft_out : h_sync;
	dbsm_top dbsm_top_inst (.ref_clk(ref_clk), .rst(rst), .host_strobe_n(strobe_n),
		.read_not_write(rnw), .map_select_pin(map_sel), .bus_select_pin(bus_sel),
		.data_in(h_wd), .data_out(data_out), .data_oe(data_oe), .frame_type_in(ft_in),
		.frame_type_out(ft_out), .frame_type_oe(ft_oe), .rx_a(rx_a), .rx_b(rx_b),
		.tx_start(tx_start), .tx_load(tx_load), .tx_word(tx_word),
		.tx_cmd_sync(tx_cmd), .tx_bus_b(tx_bus_b), .tx_off_a(tx_off_a),
		.tx_off_b(tx_off_b), .word_ready_a(rdy_a), .word_ready_b(rdy_b));
	dbsm_host dbsm_host_inst (.ref_clk(ref_clk), .rd_data(rd_bus), .sync_in(ft_in),
		.strobe_n(strobe_n), .rnw(rnw), .map_sel(map_sel), .wr_data(h_wd),
		.sync_out(h_sync));
	// Clock, 8 ns period
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Capture each transmit load pulse
	always @(posedge ref_clk) begin
		if (tx_load === 1'b1) begin
			loads <= loads + 1;
			seen_word <= tx_word;
			seen_flags <= {tx_bus_b, tx_cmd};
		end
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic rd, input logic map, input logic [15:0] wd,
		input logic sy);
		dbsm_host_inst.xfer(rd, map, wd, sy, rdv, rsy);
	endtask
	// Decoder delivers a good word on bus A or B, then ready is awaited
	task automatic rxp(input logic b, input logic [15:0] w, input logic s);
		int n;
		@(posedge ref_clk);
		if (b) begin
			rx_b.word_valid <= 1'b1; rx_b.word <= w; rx_b.word_sync <= s;
		end else begin
			rx_a.word_valid <= 1'b1; rx_a.word <= w; rx_a.word_sync <= s;
		end
		@(posedge ref_clk);
		rx_a.word_valid <= 1'b0;
		rx_b.word_valid <= 1'b0;
		for (n = 0; n < 10 && (b ? rdy_b : rdy_a) !== 1'b1; n++) @(posedge ref_clk);
		if (n == 10) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	initial begin
		rst = 1'b1; bus_sel = 1'b0; tx_start = 1'b0; rx_a = '0; rx_b = '0;
		error_cnt = 0; cmp_count = 0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		acc(1, 1, 0, 0); check(rdv, 16'h220c);
		foreach (rows[i]) begin
			acc(0, 1, rows[i][0], 0);
			acc(1, 1, 0, 0); check(rdv, rows[i][1]);
			check({tx_off_b, tx_off_a}, rows[i][0] & 16'h0003);
		end
		// Every mix of register bit and pin for sync type and bus
		for (int i = 0; i < 16; i++) begin
			k = i[3:0];
			acc(0, 1, {10'h000, k[2], k[0], 4'hc}, 0);
			@(posedge ref_clk) bus_sel <= k[3];
			acc(0, 0, 16'ha5a5 ^ i[15:0], k[1]); check(seen_word, 16'ha5a5 ^ i[15:0]);
			check(seen_flags, {k[3] | k[2], k[1] | k[0]});
		end
		acc(0, 1, 16'h000c, 0);
		@(posedge ref_clk) bus_sel <= 1'b0;
		rxp(0, 16'h1234, 1); check(rdy_a, 1);
		acc(1, 1, 0, 0); check(rdv, 16'h238c);
		acc(1, 0, 0, 0); check(rdv, 16'h1234);
		check(rsy, 1);
		check(rdy_a, 0);
		check({data_oe, ft_oe}, 0);
		rxp(1, 16'hbeef, 0);
		@(posedge ref_clk) bus_sel <= 1'b1;
		acc(1, 0, 0, 0); check(rdv, 16'hbeef);
		check(rdy_b, 0);
		@(posedge ref_clk) bus_sel <= 1'b0;
		// New word start clears ready but keeps stored data
		rxp(0, 16'h0f0f, 0);
		@(posedge ref_clk) rx_a.word_start <= 1'b1;
		@(posedge ref_clk) rx_a.word_start <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(rdy_a, 0);
		acc(1, 0, 0, 0); check(rdv, 16'h0f0f);
		check(rsy, 0);
		@(posedge ref_clk) rx_a.activity <= 1'b1;
		rx_a.code_err <= 1'b1;
		@(posedge ref_clk) rx_a.code_err <= 1'b0;
		acc(1, 1, 0, 0); check(rdv, 16'h240c);
		rx_a.activity <= 1'b0;
		acc(0, 1, 16'h0008, 0);
		@(posedge ref_clk) rx_a.word_valid <= 1'b1;
		@(posedge ref_clk) rx_a.word_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(rdy_a, 0);
		acc(0, 1, 16'h000c, 0);
		// Send window opens and closes after a transmission starts
		@(posedge ref_clk) tx_start <= 1'b1;
		@(posedge ref_clk) tx_start <= 1'b0;
		repeat (420) @(posedge ref_clk);
		acc(1, 1, 0, 0); check(rdv[15], 0);
		repeat (20) @(posedge ref_clk);
		acc(1, 1, 0, 0); check(rdv[15], 1);
		repeat (1870) @(posedge ref_clk);
		acc(1, 1, 0, 0); check(rdv[15], 0);
		acc(0, 1, 16'h0033, 0);
		@(posedge ref_clk) rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		acc(1, 1, 0, 0); check(rdv, 16'h220c);
		check({tx_off_b, tx_off_a}, 0);
		check(loads, 16);
		report_and_stop();
	end
endmodule
`default_nettype wire
